// ---- hw/pwmdac_top.sv ----
// Behaviour
// - Three pins, each with independent duty value.
// - Counter width select picks 8 or 9 bits.
// - 8-bit: 4.4 kHz or 440 Hz, 256 steps.
// - 9-bit: 2.2 kHz or 220 Hz, 512 steps.
// - Basic clock select picks output frequency.
// - Timer 3 counts basic clock, 8 bits.
// - Timer mode select shares counter timer/PWM.
// - Counter clear bit clears shared counter.
// - Per-pin function select bits 2..0.
// - Select 0 port output, 1 PWM.
// - Timer mode forces all pins to port.
// - Top select-register bit reads zero.
// - Selects cleared by reset, kept by CE.
// - High while duty exceeds counter, else low.
// - Basic clock 1.125 MHz or 112.5 kHz.
// - Reset loads every duty register with 1FF.
`timescale 1ns/1ps
`default_nettype none
`include "pwmdac_map.svh"

module pwmdac_top
   import pwmdac_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_reset_n_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  duty_out_i,
   output logic [2:0]       duty_out_o,
   output logic [2:0]       duty_out_oe_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants.

   localparam logic [21:0] ACC_MOD   = 22'(`PWMDAC_ACC_MOD);
   localparam logic [21:0] STEP_FAST = 22'(`PWMDAC_STEP_FAST);
   localparam logic [21:0] STEP_SLOW = 22'(`PWMDAC_STEP_SLOW);
   localparam logic [3:0]  RST_CLKSEL = `PWMDAC_RST_CLKSEL;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   pwmdac_cfg_t cfg_q;
   logic [2:0]  pin_sel_q;
   logic [2:0]  port_q;
   logic [8:0]  duty_q [3];
   logic [8:0]  cnt_q;
   logic [8:0]  cnt_d;
   logic [21:0] acc_q;
   logic [21:0] acc_sum;
   logic        tick_q;
   logic        match_q;
   logic        match_evt;
   logic [2:0]  pin_meta_q;
   logic [2:0]  pin_sync_q;
   logic [2:0]  pin_oe;
   logic [2:0]  pwm_sel;
   pwmdac_req_t req;
   logic        wr_en;
   logic        clear_req;
   logic [31:0] rdata;
   logic        hit;

   ////////////////////////////////////////////////////////////////////////////
   // Bus request decode.

   // The request is captured into one record for the decoders below.
   always_comb begin
      req.valid       = psel & penable & pready;
      req.write       = pwrite;
      req.index       = paddr[8:2];
      req.mapped_page = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
      req.wdata       = pwdata;
   end

   // Writes take effect on the completing edge of the access phase.
   assign wr_en = req.valid & req.write & req.mapped_page;

   // A write of one to the clear bit requests a counter clear.
   assign clear_req = wr_en && (req.index == `PWMDAC_IDX_T3CTL) &&
                      req.wdata[`PWMDAC_BIT_CLEAR];

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   // Width, basic clock and counter use; kept through a CE reset.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cfg_q.width9     <= RST_CLKSEL[`PWMDAC_BIT_WIDTH9];
         cfg_q.basic_slow <= RST_CLKSEL[`PWMDAC_BIT_BASIC_CLK];
         cfg_q.mode       <= pwmdac_mode_t'(`PWMDAC_RST_T3MODE);
      end else if (wr_en) begin
         if (req.index == `PWMDAC_IDX_CLKSEL) begin
            cfg_q.width9     <= req.wdata[`PWMDAC_BIT_WIDTH9];
            cfg_q.basic_slow <= req.wdata[`PWMDAC_BIT_BASIC_CLK];
         end
         if (req.index == `PWMDAC_IDX_T3CTL) begin
            cfg_q.mode <= pwmdac_mode_t'(req.wdata[`PWMDAC_BIT_TMODE]);
         end
      end
   end

   // Pin function selects: cleared by the main reset only.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_sel_q <= `PWMDAC_RST_PINSEL;
      end else if (wr_en && (req.index == `PWMDAC_IDX_PINSEL)) begin
         pin_sel_q <= req.wdata[2:0];
      end
   end

   // Port output latch used while a pin is a general-purpose output.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         port_q <= `PWMDAC_RST_PORT;
      end else if (wr_en && (req.index == `PWMDAC_IDX_PORT)) begin
         port_q <= req.wdata[2:0];
      end
   end

   // Duty registers; the third one doubles as the timer 3 modulo value.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 3; i++) begin
            duty_q[i] <= `PWMDAC_RST_DUTY;
         end
      end else if (wr_en) begin
         if (req.index == `PWMDAC_IDX_DUTY0) begin
            duty_q[0] <= req.wdata[8:0];
         end
         if (req.index == `PWMDAC_IDX_DUTY1) begin
            duty_q[1] <= req.wdata[8:0];
         end
         if (req.index == `PWMDAC_IDX_DUTY2) begin
            duty_q[2] <= req.wdata[8:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Basic clock generation.

   // Fractional accumulator; the average tick rate is exact.
   assign acc_sum = acc_q + (cfg_q.basic_slow ? STEP_SLOW : STEP_FAST);

   // One-cycle basic clock enable from the accumulator overflow.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_q  <= 22'h000000;
         tick_q <= 1'b0;
      end else if (acc_sum >= ACC_MOD) begin
         acc_q  <= acc_sum - ACC_MOD;
         tick_q <= 1'b1;
      end else begin
         acc_q  <= acc_sum;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared counter.

   // Next counter value for either use of the counter.
   always_comb begin
      cnt_d     = cnt_q;
      match_evt = 1'b0;
      if (tick_q) begin
         if (cfg_q.mode == PWMDAC_MODE_TIMER) begin
            if (cnt_q[7:0] == duty_q[2][7:0]) begin
               cnt_d     = 9'h000;
               match_evt = 1'b1;
            end else begin
               cnt_d = {1'b0, cnt_q[7:0] + 8'h01};
            end
         end else if (cnt_q >= (cfg_q.width9 ? `PWMDAC_CNT_TOP9
                                             : `PWMDAC_CNT_TOP8)) begin
            cnt_d = 9'h000;
         end else begin
            cnt_d = cnt_q + 9'h001;
         end
      end
   end

   // Counter register; the clear bit and a CE reset restart it.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !ce_reset_n_i) begin
         cnt_q <= 9'h000;
      end else if (clear_req) begin
         cnt_q <= 9'h000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Sticky timer match flag; a new match wins over a clear.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !ce_reset_n_i) begin
         match_q <= 1'b0;
      end else if (match_evt) begin
         match_q <= 1'b1;
      end else if (wr_en && (req.index == `PWMDAC_IDX_STATUS) &&
                   req.wdata[`PWMDAC_BIT_MATCH]) begin
         match_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pins.

   // A pin is in PWM use only when selected and the counter is not a timer.
   assign pwm_sel = pin_sel_q & {3{cfg_q.mode == PWMDAC_MODE_PWM}};

   // One comparator per pin, each with its own duty value.
   for (genvar k = 0; k < 3; k++) begin : g_pin
      pwmdac_cmp u_cmp (
         .clk_i        (clk_i),
         .reset_n_i    (reset_n_i),
         .duty_i       (duty_q[k]),
         .cnt_i        (cnt_q),
         .width9_i     (cfg_q.width9),
         .pwm_sel_i    (pwm_sel[k]),
         .port_level_i (port_q[k]),
         .pin_oe_o     (pin_oe[k])
      );
   end

   assign duty_out_oe_o = pin_oe;

   // The open-drain driver only ever pulls low.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         duty_out_o <= 3'h0;
      end else begin
         duty_out_o <= 3'h0;
      end
   end

   // Pin readback passes two flip-flops before use.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_meta_q <= 3'h0;
         pin_sync_q <= 3'h0;
      end else begin
         pin_meta_q <= duty_out_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data and bus answer.

   // Read multiplexer; unlisted bits read as zero.
   always_comb begin
      rdata = 32'h00000000;
      hit   = req.mapped_page;
      case (req.index)
         `PWMDAC_IDX_CLKSEL: begin
            rdata[`PWMDAC_BIT_WIDTH9]    = cfg_q.width9;
            rdata[`PWMDAC_BIT_BASIC_CLK] = cfg_q.basic_slow;
         end
         `PWMDAC_IDX_PINSEL: begin
            rdata[2:0] = pin_sel_q;
            rdata[3]   = 1'b0;
         end
         `PWMDAC_IDX_T3CTL: begin
            rdata[`PWMDAC_BIT_TMODE] = cfg_q.mode;
         end
         `PWMDAC_IDX_PORT: begin
            rdata[2:0] = port_q;
         end
         `PWMDAC_IDX_STATUS: begin
            rdata[`PWMDAC_LSB_CNT +: 9]    = cnt_q;
            rdata[`PWMDAC_LSB_DRIVE +: 3]  = ~pin_oe;
            rdata[`PWMDAC_LSB_PIN_IN +: 3] = pin_sync_q;
            rdata[`PWMDAC_BIT_MATCH]       = match_q;
         end
         `PWMDAC_IDX_DUTY0: begin
            rdata[8:0] = duty_q[0];
         end
         `PWMDAC_IDX_DUTY1: begin
            rdata[8:0] = duty_q[1];
         end
         `PWMDAC_IDX_DUTY2: begin
            rdata[8:0] = duty_q[2];
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // No wait state: ready rises in the first access cycle and drops after.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= ~hit;
         prdata  <= (hit && !pwrite) ? rdata : 32'h00000000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end

endmodule

`default_nettype wire

// ---- hw/pwmdac_map.svh ----
`ifndef PWMDAC_MAP_SVH
`define PWMDAC_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define PWMDAC_IDX_CLKSEL    7'h26
`define PWMDAC_IDX_PINSEL    7'h27
`define PWMDAC_IDX_T3CTL     7'h1A
`define PWMDAC_IDX_PORT      7'h29
`define PWMDAC_IDX_STATUS    7'h2A
`define PWMDAC_IDX_DUTY0     7'h44
`define PWMDAC_IDX_DUTY1     7'h45
`define PWMDAC_IDX_DUTY2     7'h46

// Field positions.
`define PWMDAC_BIT_BASIC_CLK 0
`define PWMDAC_BIT_WIDTH9    2
`define PWMDAC_BIT_CLEAR     0
`define PWMDAC_BIT_TMODE     3
`define PWMDAC_LSB_CNT       0
`define PWMDAC_LSB_DRIVE     9
`define PWMDAC_LSB_PIN_IN    12
`define PWMDAC_BIT_MATCH     15

// Reset values.
`define PWMDAC_RST_CLKSEL    4'h0
`define PWMDAC_RST_PINSEL    3'h0
`define PWMDAC_RST_T3MODE    1'h0
`define PWMDAC_RST_PORT      3'h0
`define PWMDAC_RST_DUTY      9'h1FF

// Timing: system clock and the two basic clock rates, in Hz.
`define PWMDAC_CLK_HZ        200000000
`define PWMDAC_BASIC_FAST_HZ 1125000
`define PWMDAC_BASIC_SLOW_HZ 112500
`define PWMDAC_ACC_UNIT_HZ   50
`define PWMDAC_ACC_MOD       (`PWMDAC_CLK_HZ / `PWMDAC_ACC_UNIT_HZ)
`define PWMDAC_STEP_FAST     (`PWMDAC_BASIC_FAST_HZ / `PWMDAC_ACC_UNIT_HZ)
`define PWMDAC_STEP_SLOW     (`PWMDAC_BASIC_SLOW_HZ / `PWMDAC_ACC_UNIT_HZ)

// Counter end values.
`define PWMDAC_CNT_TOP8      9'h0FF
`define PWMDAC_CNT_TOP9      9'h1FF

`endif

// ---- hw/pwmdac_pkg.sv ----
package pwmdac_pkg;

   // Use of the shared counter.
   typedef enum logic [0:0] {
      PWMDAC_MODE_PWM   = 1'b0,
      PWMDAC_MODE_TIMER = 1'b1
   } pwmdac_mode_t;

   // Clock and counter configuration travelling together.
   typedef struct packed {
      logic         width9;
      logic         basic_slow;
      pwmdac_mode_t mode;
   } pwmdac_cfg_t;

   // One decoded bus request.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [6:0]  index;
      logic        mapped_page;
      logic [31:0] wdata;
   } pwmdac_req_t;

endpackage

// ---- hw/pwmdac_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none

module pwmdac_cmp
   import pwmdac_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [8:0] duty_i,
   input  wire logic [8:0] cnt_i,
   input  wire logic       width9_i,
   input  wire logic       pwm_sel_i,
   input  wire logic       port_level_i,
   output logic            pin_oe_o
);

   logic level;

   // Pin level: if PWM-selected, high while duty is above counter, else low; otherwise port latch value.
   always_comb begin
      if (pwm_sel_i) begin
         if (width9_i) begin
            level = (duty_i > cnt_i);
         end else begin
            level = (duty_i[7:0] > cnt_i[7:0]);
         end
      end else begin
         level = port_level_i;
      end
   end

   // Open-drain pin: a low level pulls, a high level releases to the pull-up.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_oe_o <= 1'b1;
      end else begin
         pin_oe_o <= ~level;
      end
   end

endmodule

`default_nettype wire

// ---- test/pwmdac_pullup_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pwmdac_pullup_model
(
   input  wire logic [2:0] oe_i,
   output logic [2:0]      line_o
);
   // Each line is held high by its resistor unless the pin pulls it low.
   assign line_o = ~oe_i;
endmodule

`default_nettype wire

// ---- test/pwmdac_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwmdac_map.svh"

module pwmdac_chk
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [2:0]  duty_out_o,
   input  wire logic [2:0]  duty_out_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   ////////////////////////////////////////
   // The bus answers in the cycle after setup, for one cycle only.
   a_ready_after_setup: assert property (disable iff (!reset_n_i)
      psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_one_cycle: assert property (disable iff (!reset_n_i)
      pready |=> !pready) else $error("ready held too long");
   a_err_with_ready: assert property (disable iff (!reset_n_i)
      pslverr |-> pready) else $error("error without ready");
   a_idle_rdata_zero: assert property (disable iff (!reset_n_i)
      !pready |-> prdata == 32'h0) else $error("read data outside answer");
   a_misaligned_err: assert property (disable iff (!reset_n_i)
      psel && !penable && paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned accepted");
   a_high_page_err: assert property (disable iff (!reset_n_i)
      psel && !penable && paddr[11:9] != 3'h0 |=> pslverr) else $error("high page accepted");
   // Pin output data and the top select bit are fixed at zero.
   a_top_bit_zero: assert property (disable iff (!reset_n_i)
      psel && !penable && !pwrite && paddr == {3'h0, `PWMDAC_IDX_PINSEL, 2'h0}
      |=> prdata[3] == 1'b0) else $error("top bit set");
   a_out_never_high: assert property (disable iff (!reset_n_i)
      duty_out_o == 3'h0) else $error("pin data driven high");
   // Reset leaves every pin pulled low as a port.
   a_reset_pins_low: assert property (!reset_n_i |=> duty_out_oe_o == 3'h7)
      else $error("pins not low after reset");
   cover property (disable iff (!reset_n_i) pready && pwrite);
   cover property (disable iff (!reset_n_i) pslverr);
   cover property (disable iff (!reset_n_i) $changed(duty_out_oe_o));
endmodule

bind pwmdac_top pwmdac_chk pwmdac_chk_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .duty_out_o(duty_out_o), .duty_out_oe_o(duty_out_oe_o));

`default_nettype wire

// ---- test/pwm_dac_output_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwmdac_map.svh"

module pwm_dac_output_unit_bench
   import pwmdac_pkg::*;
;
   logic        clk_i, reset_n_i, ce_reset_n_i, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  pin_line, duty_out, duty_oe;
   logic [8:0]  cnt;
   int          miscompares, check_count;

   pwmdac_top pwmdac_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_reset_n_i(ce_reset_n_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .duty_out_i(pin_line),
      .duty_out_o(duty_out), .duty_out_oe_o(duty_oe));
   pwmdac_pullup_model pwmdac_pullup_model_i (.oe_i(duty_oe), .line_o(pin_line));

   ////////////////////////////////////////
   // Verdict and comparison helpers.
   task automatic results();
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One APB transfer to a byte address; the request stands until pready is seen at an edge.
   task automatic apb_raw(input logic wr, input logic [11:0] addr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      check("pready", {31'h0, pready === 1'b1}, 32'h1);
   endtask
   // One APB transfer to a register index.
   task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] d);
      apb_raw(wr, {3'h0, idx, 2'h0}, d);
   endtask
   task automatic rdchk(input string name, input logic [6:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(name, rd, exp);
   endtask
   // Pin levels as the pull-ups show them; the data output never drives high.
   task automatic pins(input string name, input logic [2:0] exp);
      repeat (3) @(negedge clk_i);
      check(name, {29'h0, pin_line}, {29'h0, exp});
      check("pin data", {29'h0, duty_out}, 32'h0);
   endtask
   task automatic status();
      apb(1'b0, `PWMDAC_IDX_STATUS, 32'h0);
      cnt = rd[8:0];
   endtask

   ////////////////////////////////////////
   // Scenarios.
   task automatic t_reset_state();
      rdchk("pinsel", `PWMDAC_IDX_PINSEL, 32'h0);
      for (int i = 0; i < 3; i++) rdchk("duty", `PWMDAC_IDX_DUTY0 + 7'(i), 32'h1FF);
      pins("reset pins", 3'h0);
      apb(1'b0, 7'h7F, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      apb_raw(1'b1, {3'h0, `PWMDAC_IDX_DUTY0, 2'h1}, 32'h0);
      check("misaligned err", {31'h0, err}, 32'h1);
      apb_raw(1'b1, {3'h1, `PWMDAC_IDX_DUTY0, 2'h0}, 32'h0);
      check("high page err", {31'h0, err}, 32'h1);
      rdchk("refused duty", `PWMDAC_IDX_DUTY0, 32'h1FF);
   endtask
   task automatic t_select_port();
      apb(1'b1, `PWMDAC_IDX_PINSEL, 32'hF);
      rdchk("pinsel top", `PWMDAC_IDX_PINSEL, 32'h7);
      apb(1'b1, `PWMDAC_IDX_PINSEL, 32'h0);
      apb(1'b1, `PWMDAC_IDX_PORT, 32'h5);
      pins("port levels", 3'h5);
      status();
      check("drive levels", {29'h0, rd[11:9]}, 32'h5);
      check("pin readback", {29'h0, rd[14:12]}, 32'h5);
   endtask
   task automatic t_pwm_width();
      apb(1'b1, `PWMDAC_IDX_DUTY0, 32'h0);
      apb(1'b1, `PWMDAC_IDX_DUTY1, 32'h1FF);
      apb(1'b1, `PWMDAC_IDX_DUTY2, 32'h100);
      apb(1'b1, `PWMDAC_IDX_CLKSEL, 32'h4);
      rdchk("clksel", `PWMDAC_IDX_CLKSEL, 32'h4);
      apb(1'b1, `PWMDAC_IDX_T3CTL, 32'h1);
      apb(1'b1, `PWMDAC_IDX_PINSEL, 32'h7);
      pins("pwm 9 bit low count", 3'h6);
      apb(1'b1, `PWMDAC_IDX_CLKSEL, 32'h0);
      pins("pwm 8 bit", 3'h2);
      apb(1'b1, `PWMDAC_IDX_CLKSEL, 32'h4);
      cnt = 9'h0;
      for (int n = 0; n < 16000 && cnt < 9'h100; n++) status();
      check("count above 255", {31'h0, cnt >= 9'h100}, 32'h1);
      // A second read lets the pin comparison settle on the new count.
      status();
      check("drive high count", {29'h0, rd[11:9]}, 32'h2);
   endtask
   task automatic t_basic_clock();
      apb(1'b1, `PWMDAC_IDX_T3CTL, 32'h1);
      status();
      check("cleared", {31'h0, cnt < 9'h2}, 32'h1);
      apb(1'b1, `PWMDAC_IDX_T3CTL, 32'h1);
      repeat (1778) @(posedge clk_i);
      status();
      check("fast ticks", {31'h0, cnt >= 9'h9 && cnt <= 9'hB}, 32'h1);
      apb(1'b1, `PWMDAC_IDX_CLKSEL, 32'h5);
      rdchk("clksel slow", `PWMDAC_IDX_CLKSEL, 32'h5);
      apb(1'b1, `PWMDAC_IDX_T3CTL, 32'h1);
      // Shorter than one slow tick period, so at most one tick can land.
      repeat (1700) @(posedge clk_i);
      status();
      check("slow ticks", {31'h0, cnt <= 9'h1}, 32'h1);
   endtask
   task automatic t_timer();
      apb(1'b1, `PWMDAC_IDX_CLKSEL, 32'h4);
      apb(1'b1, `PWMDAC_IDX_DUTY2, 32'h3);
      apb(1'b1, `PWMDAC_IDX_PORT, 32'h0);
      apb(1'b1, `PWMDAC_IDX_T3CTL, 32'h8);
      rdchk("t3ctl", `PWMDAC_IDX_T3CTL, 32'h8);
      pins("timer forces port", 3'h0);
      repeat (2000) @(posedge clk_i);
      status();
      check("timer modulo", {31'h0, cnt <= 9'h3}, 32'h1);
      check("timer match", {31'h0, rd[15]}, 32'h1);
      apb(1'b1, `PWMDAC_IDX_T3CTL, 32'h1);
      apb(1'b1, `PWMDAC_IDX_STATUS, 32'h8000);
      status();
      check("match cleared", {31'h0, rd[15]}, 32'h0);
      pins("back to pwm", 3'h6);
   endtask
   task automatic t_resets();
      @(posedge clk_i);
      ce_reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      ce_reset_n_i <= 1'b1;
      rdchk("ce pinsel", `PWMDAC_IDX_PINSEL, 32'h7);
      rdchk("ce duty", `PWMDAC_IDX_DUTY2, 32'h3);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rdchk("por pinsel", `PWMDAC_IDX_PINSEL, 32'h0);
      rdchk("por duty", `PWMDAC_IDX_DUTY2, 32'h1FF);
      rdchk("por clksel", `PWMDAC_IDX_CLKSEL, 32'h0);
      pins("por pins", 3'h0);
   endtask

   ////////////////////////////////////////
   // Clock, main sequence and watchdog.
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      reset_n_i    = 1'b0;
      ce_reset_n_i = 1'b1;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 12'h000;
      pwdata       = 32'h00000000;
      miscompares  = 0;
      check_count  = 0;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset_state();
      t_select_port();
      t_pwm_width();
      t_basic_clock();
      t_timer();
      t_resets();
      results();
   end
   // The scenarios need about 51,000 cycles; the watchdog allows 80,000.
   initial begin
      #400000;
      miscompares++;
      results();
   end
endmodule

`default_nettype wire
